// *** logic/ahs_fifo.v ***
`timescale 1ns/100ps
`default_nettype none

module ahs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
)(
  input wire sys_clk_in, // clock
  input wire rst_in, // async reset, high
  input wire in_valid_in, // write request
  output wire in_ready_out, // room available
  input wire [WIDTH-1:0] in_data_in, // write data
  output wire out_valid_out, // data available
  input wire out_ready_in, // consumer takes data
  output wire [WIDTH-1:0] out_data_out // head data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge sys_clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** logic/ahs_map.vh ***
`ifndef AHS_MAP_VH
`define AHS_MAP_VH

// status word layout
`define AHS_ST_BUSY 7
`define AHS_ST_SIGN 6
`define AHS_ST_ZERO 5
`define AHS_ST_ERR_HI 4
`define AHS_ST_ERR_LO 1
`define AHS_ST_CARRY 0
`define AHS_STATUS_RESET 8'h00

// error field codes
`define AHS_ERR_NONE 4'h0
`define AHS_ERR_DIV0 4'h8
`define AHS_ERR_NEG 4'h4
`define AHS_ERR_ARG 4'hC
`define AHS_ERR_UNDER_BIT 1
`define AHS_ERR_OVER_BIT 0

// command byte fields
`define AHS_CMD_SVC_BIT 7
`define AHS_CMD_FMT_HI 6
`define AHS_CMD_FMT_LO 5
`define AHS_FMT_FIX16 2'h3
`define AHS_FMT_FIX32 2'h1
`define AHS_FMT_FLOAT 2'h0

// operand and stack geometry
`define AHS_FIX16_W 16
`define AHS_FIX32_W 32
`define AHS_FLT_SIGN 31
`define AHS_FLT_EXP_HI 30
`define AHS_FLT_EXP_LO 24
`define AHS_FLT_MANT_HI 23
`define AHS_STACK_BYTES 16
`define AHS_STACK_LEVELS 8

// timing and buffering
`define AHS_EXEC_CYCLES 4
`define AHS_FIFO_DEPTH 8
`define AHS_SYNC_BITS 14

`endif

// *** logic/ahs_port.v ***
`timescale 1ns/100ps
`default_nettype none
`include "ahs_map.vh"

module ahs_port #(
  parameter EXEC_CYCLES = `AHS_EXEC_CYCLES,
  parameter CNT_W = 16,
  parameter FIFO_DEPTH = `AHS_FIFO_DEPTH
)(
  input wire sys_clk_in, // device clock
  input wire rst_in, // async reset, high
  input wire cs_n_in, // chip select, low
  input wire cd_in, // 1 command/status, 0 stack data
  input wire rd_n_in, // read strobe, low
  input wire wr_n_in, // write strobe, low
  input wire [7:0] data_in, // bus data from host
  output reg [7:0] data_out, // bus data to host
  output reg data_oe_out, // drive data bus
  output wire pause_n_out, // bus wait, low
  output wire done_n_out, // command complete, low
  input wire done_ack_n_in, // completion ack, low pulse
  output reg service_request_out, // service request, high
  input wire service_ack_n_in, // service ack, low pulse
  input wire [3:0] core_error_in, // error code from arithmetic core
  input wire core_carry_in, // carry from arithmetic core
  output reg [7:0] cmd_out, // command being executed
  output reg [31:0] op_top_out, // stack_top operand
  output reg [31:0] op_second_out, // stack_second operand
  output wire busy_out // command executing
);

  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  // three-stage input filtering of every asynchronous pin
  wire [`AHS_SYNC_BITS-1:0] raw_pins;
  wire [`AHS_SYNC_BITS-1:0] filt;

  assign raw_pins = {service_ack_n_in, done_ack_n_in, wr_n_in, rd_n_in,
    cd_in, cs_n_in, data_in};

  genvar gi;
  generate
    for (gi = 0; gi < `AHS_SYNC_BITS; gi = gi + 1)
    begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg f;
      always @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          f <= 1'b1;
        end
        else
        begin
          s1 <= raw_pins[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            f <= s3;
        end
      end
      assign filt[gi] = f;
    end
  endgenerate

  wire [7:0] bus_byte;
  wire cs_n_f;
  wire cd_f;
  wire rd_n_f;
  wire wr_n_f;
  wire ack_n_f;
  wire service_ack_n_n_f;

  assign bus_byte = filt[7:0];
  assign cs_n_f = filt[8];
  assign cd_f = filt[9];
  assign rd_n_f = filt[10];
  assign wr_n_f = filt[11];
  assign ack_n_f = filt[12];
  assign service_ack_n_n_f = filt[13];

  wire access;
  wire is_read;

  assign access = ~cs_n_f & (~rd_n_f | ~wr_n_f);
  assign is_read = ~rd_n_f;

  // operand stack, contents survive reset
  reg [7:0] stack_mem [0:`AHS_STACK_BYTES-1];
  reg [3:0] top_ptr;
  reg busy;
  reg state;
  reg [CNT_W-1:0] exec_cnt;
  reg [7:0] status;
  reg done_flag;
  reg ack_prev;
  reg service_ack_n_prev;

  // eight-byte FIFO between bus and stack
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire drain;

  // view of the eight bytes nearest the top
  wire [63:0] view;
  generate
    for (gi = 0; gi < `AHS_STACK_LEVELS; gi = gi + 1)
    begin : g_view
      localparam [3:0] OFF = gi;
      assign view[63-8*gi -: 8] = stack_mem[top_ptr + OFF];
    end
  endgenerate

  wire svc_state_idle;
  wire do_status;
  wire do_pop;
  wire do_cmd;
  wire do_push;
  wire finish;

  assign svc_state_idle = (state == ST_IDLE) & access;
  assign do_status = svc_state_idle & is_read & cd_f;
  assign do_pop = svc_state_idle & is_read & ~cd_f & ~busy &
    ~fifo_out_valid;
  assign do_cmd = svc_state_idle & ~is_read & cd_f & ~busy &
    ~fifo_out_valid;
  assign do_push = svc_state_idle & ~is_read & ~cd_f & ~busy &
    fifo_in_ready;
  assign finish = busy & (exec_cnt == {CNT_W{1'b0}});

  assign pause_n_out = ~svc_state_idle |
    (do_status | do_pop | do_cmd | do_push);
  assign done_n_out = ~done_flag;
  assign busy_out = busy;
  // stack is frozen while a command runs
  assign drain = fifo_out_valid & ~busy;

  ahs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(do_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(bus_byte),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(~busy),
    .out_data_out(fifo_out_data)
  );

  always @(posedge sys_clk_in)
  begin
    if (drain)
      stack_mem[top_ptr - 4'h1] <= fifo_out_data;
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      top_ptr <= 4'h0;
    else if (drain)
      top_ptr <= top_ptr - 4'h1;
    else if (do_pop)
      top_ptr <= top_ptr + 4'h1;
  end

  // bus hand-shake and data latch
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (do_status)
            data_out <= status;
          else if (do_pop)
            data_out <= view[63:56];
          if (do_status | do_pop)
            data_oe_out <= 1'b1;
          if (do_status | do_pop | do_cmd | do_push)
            state <= ST_HOLD;
        end
        ST_HOLD:
        begin
          if (~access)
          begin
            state <= ST_IDLE;
            data_oe_out <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          data_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // format of the running command
  wire [1:0] fmt;
  wire is_fix16;
  wire [31:0] top16;
  wire [31:0] second16;

  assign fmt = cmd_out[`AHS_CMD_FMT_HI:`AHS_CMD_FMT_LO];
  assign is_fix16 = (fmt == `AHS_FMT_FIX16);
  assign top16 = {{16{view[63]}}, view[63:48]};
  assign second16 = {{16{view[47]}}, view[47:32]};

  wire [1:0] new_fmt;
  assign new_fmt = bus_byte[`AHS_CMD_FMT_HI:`AHS_CMD_FMT_LO];

  // result flags taken from the stack top at completion
  wire res_sign;
  wire res_zero;
  wire [31:0] res_top;
  assign res_top = is_fix16 ? top16 : view[63:32];
  assign res_sign = res_top[`AHS_FLT_SIGN];
  assign res_zero = (res_top == 32'h0000_0000);

  // command execution
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy <= 1'b0;
      exec_cnt <= {CNT_W{1'b0}};
      cmd_out <= 8'h00;
      op_top_out <= 32'h0000_0000;
      op_second_out <= 32'h0000_0000;
      status <= `AHS_STATUS_RESET;
    end
    else
    begin
      if (do_cmd)
      begin
        busy <= 1'b1;
        exec_cnt <= EXEC_CYCLES[CNT_W-1:0] - 1'b1;
        cmd_out <= bus_byte;
        status[`AHS_ST_BUSY] <= 1'b1;
        if (new_fmt == `AHS_FMT_FIX16)
        begin
          op_top_out <= top16;
          op_second_out <= second16;
        end
        else
        begin
          op_top_out <= view[63:32];
          op_second_out <= view[31:0];
        end
      end
      else if (finish)
      begin
        busy <= 1'b0;
        status[`AHS_ST_BUSY] <= 1'b0;
        status[`AHS_ST_SIGN] <= res_sign;
        status[`AHS_ST_ZERO] <= res_zero;
        status[`AHS_ST_CARRY] <= core_carry_in;
        status[`AHS_ST_ERR_HI:`AHS_ST_ERR_LO] <= core_error_in;
      end
      else if (busy)
        exec_cnt <= exec_cnt - 1'b1;
    end
  end

  // completion and service request flags
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_flag <= 1'b0;
      service_request_out <= 1'b0;
      ack_prev <= 1'b1;
      service_ack_n_prev <= 1'b1;
    end
    else
    begin
      ack_prev <= ack_n_f;
      service_ack_n_prev <= service_ack_n_n_f;
      if (finish)
        done_flag <= 1'b1;
      else if (ack_prev & ~ack_n_f)
        done_flag <= 1'b0;
      if (finish & cmd_out[`AHS_CMD_SVC_BIT])
        service_request_out <= 1'b1;
      else if (service_ack_n_prev & ~service_ack_n_n_f)
        service_request_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** sim/ahs_host.sv ***
`timescale 1ns/100ps
`default_nettype none

module ahs_host (
  input wire logic sys_clk_in, // clock
  input wire logic pause_n_in, // wait from device
  input wire logic [7:0] bus_in, // resolved bus
  output var logic cs_n_out, // chip select
  output var logic cd_out, // command/data
  output var logic rd_n_out, // read strobe
  output var logic wr_n_out, // write strobe
  output var logic [7:0] d_out, // write byte
  output var logic oe_out // host drives bus
);
  // cycles that the last access spent waiting on pause
  integer waits;
  initial
  begin
    cs_n_out = 1'b1;
    cd_out = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    d_out = 8'h00;
    oe_out = 1'b0;
  end
  task tk;
  begin
    @(posedge sys_clk_in);
    #2;
  end
  endtask
  // one bus access: c selects command/status, r selects read
  task acc(input logic c, input logic r, input logic [7:0] w,
    output logic [7:0] q);
    integer n;
  begin
    tk;
    cs_n_out = 1'b0;
    cd_out = c;
    d_out = w;
    oe_out = !r;
    rd_n_out = !r;
    wr_n_out = r;
    repeat (6) tk;
    n = 0;
    while (!pause_n_in && n < 40000)
    begin
      tk;
      n = n + 1;
    end
    waits = n;
    tk;
    tk;
    q = bus_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    oe_out = 1'b0;
    repeat (6) tk;
  end
  endtask
endmodule

`default_nettype wire

// *** sim/ahs_port_sva.sv ***
`timescale 1ns/100ps
`default_nettype none

module ahs_port_sva #(
  parameter EXEC_CYCLES = 4
)(
  input wire logic sys_clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic cs_n_in, // chip select
  input wire logic cd_in, // command/data
  input wire logic rd_n_in, // read strobe
  input wire logic wr_n_in, // write strobe
  input wire logic data_oe_out, // bus drive
  input wire logic pause_n_out, // wait
  input wire logic done_n_out, // completion
  input wire logic done_ack_n_in, // completion ack
  input wire logic service_request_out, // service request
  input wire logic service_ack_n_in, // service ack
  input wire logic [7:0] cmd_out, // running command
  input wire logic busy_out // executing
);
  reg [15:0] busy_cnt;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // length of the current busy stretch
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_out ? busy_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_finish;
    $fell(busy_out);
  endsequence
  busy_done_a: assert property (s_finish |-> !done_n_out)
    else $error("completion not flagged with busy clear");
  done_cause_a: assert property ($fell(done_n_out) |-> s_finish)
    else $error("completion without busy clear");
  exec_len_a: assert property (s_finish |-> busy_cnt == EXEC_CYCLES)
    else $error("busy length wrong");
  svc_set_a: assert property (s_finish ##0 cmd_out[7] |-> service_request_out)
    else $error("service request not raised");
  svc_cause_a: assert property ($rose(service_request_out) |-> s_finish)
    else $error("service request outside completion");
  done_rel_a: assert property (!done_n_out && $fell(done_ack_n_in)
    |-> ##[2:7] done_n_out)
    else $error("completion not released");
  svc_rel_a: assert property (service_request_out && $fell(service_ack_n_in)
    |-> ##[2:7] !service_request_out)
    else $error("service request not cleared");
  pause_busy_a: assert property ($rose(pause_n_out) |-> !busy_out)
    else $error("pause released while busy");
  read_drive_a: assert property ($rose(data_oe_out) |-> !cs_n_in && !rd_n_in)
    else $error("bus driven without read");
  cmd_start_a: assert property ($rose(busy_out)
    |-> !cs_n_in && cd_in && !wr_n_in)
    else $error("busy without command write");
endmodule

bind ahs_port ahs_port_sva #(.EXEC_CYCLES(EXEC_CYCLES)) i_ahs_port_sva (
  .sys_clk_in, .rst_in, .cs_n_in, .cd_in, .rd_n_in, .wr_n_in, .data_oe_out,
  .pause_n_out, .done_n_out, .done_ack_n_in, .service_request_out,
  .service_ack_n_in, .cmd_out, .busy_out
);

`default_nettype wire

// *** sim/ahs_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module ahs_port_tb;
  logic clk, rst, cs_n, cd, rd_n, wr_n, h_oe, oe, pause_n, done_n;
  logic done_ack_n, svc_ack_n, svc, busy, carry;
  logic [7:0] h_d, bus, d_out, q, cmd;
  logic [3:0] err;
  logic [31:0] top, sec;
  logic [17:0] rows [0:5];
  integer fails, cmp_count, i;
  // released bus shows a changed pattern, not the last byte
  assign bus = oe ? d_out : (h_oe ? h_d : ~h_d);
  ahs_port #(.EXEC_CYCLES(40)) i_ahs_port (.sys_clk_in(clk), .rst_in(rst),
    .cs_n_in(cs_n), .cd_in(cd), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .data_in(bus), .data_out(d_out), .data_oe_out(oe),
    .pause_n_out(pause_n), .done_n_out(done_n), .done_ack_n_in(done_ack_n),
    .service_request_out(svc), .service_ack_n_in(svc_ack_n),
    .core_error_in(err), .core_carry_in(carry), .cmd_out(cmd),
    .op_top_out(top), .op_second_out(sec), .busy_out(busy));
  ahs_host i_ahs_host (.sys_clk_in(clk), .pause_n_in(pause_n), .bus_in(bus),
    .cs_n_out(cs_n), .cd_out(cd), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .d_out(h_d), .oe_out(h_oe));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task tk;
  begin
    @(posedge clk);
    #2;
  end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    if (g !== e)
      fails = fails + 1;
  end
  endtask
  task ack(input logic s);
  begin
    tk;
    if (s)
      svc_ack_n = 1'b0;
    else
      done_ack_n = 1'b0;
    repeat (5) tk;
    svc_ack_n = 1'b1;
    done_ack_n = 1'b1;
    repeat (6) tk;
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // whole run needs about 1000 cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    fails = fails + 1;
    end_sim;
  end
  initial
  begin
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    done_ack_n = 1'b1;
    svc_ack_n = 1'b1;
    err = 4'h8;
    carry = 1'b1;
    rows[0] = {2'b11, 8'h00, 8'h00};
    rows[1] = {2'b00, 8'hA1, 8'h00};
    rows[2] = {2'b00, 8'hB2, 8'h00};
    rows[3] = {2'b01, 8'h00, 8'hB2};
    rows[4] = {2'b01, 8'h00, 8'hA1};
    rows[5] = {2'b11, 8'h00, 8'h00};
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      i_ahs_host.acc(rows[i][17], rows[i][16], rows[i][15:8], q);
      if (rows[i][16])
        chk(32'(q), 32'(rows[i][7:0]));
    end
    // nine whole 16-bit operands, one more than the stack holds
    for (i = 0; i < 18; i = i + 1)
      i_ahs_host.acc(1'b0, 1'b0, 8'h10 + i[7:0], q);
    for (i = 0; i < 16; i = i + 1)
    begin
      i_ahs_host.acc(1'b0, 1'b1, 8'h00, q);
      chk(32'(q), 32'(8'h21 - i[7:0]));
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      i_ahs_host.acc(1'b0, 1'b1, 8'h00, q);
      chk(32'(q), 32'(8'h21 - i[7:0]));
    end
    for (i = 0; i < 4; i = i + 1)
      i_ahs_host.acc(1'b0, 1'b0, 8'h78 - 8'h22 * i[7:0], q);
    chk(i_ahs_host.waits, 0);
    i_ahs_host.acc(1'b1, 1'b0, 8'hEC, q);
    chk({busy, cmd, top[15:0]}, {1'b1, 8'hEC, 16'h1234});
    chk(sec[15:0], 16'h5678);
    i_ahs_host.acc(1'b1, 1'b1, 8'h00, q);
    chk(32'(q[7]), 32'h1);
    i_ahs_host.acc(1'b0, 1'b0, 8'hFF, q);
    chk({busy, done_n, svc}, 3'b001);
    chk(32'(i_ahs_host.waits > 0), 32'h1);
    i_ahs_host.acc(1'b1, 1'b1, 8'h00, q);
    chk(32'(q), 32'h11);
    ack(1'b0);
    chk(32'(done_n), 32'h1);
    ack(1'b1);
    chk(32'(svc), 32'h0);
    err = 4'h1;
    carry = 1'b0;
    i_ahs_host.acc(1'b1, 1'b0, 8'h60, q);
    i_ahs_host.acc(1'b1, 1'b0, 8'h20, q);
    chk({busy, cmd}, {1'b1, 8'h20});
    chk(32'(i_ahs_host.waits > 0), 32'h1);
    i = 0;
    while (busy && i < 200)
    begin
      tk;
      i = i + 1;
    end
    chk(32'(busy), 32'h0);
    chk({done_n, svc}, 2'b00);
    chk(top, 32'hFF123456);
    i_ahs_host.acc(1'b1, 1'b1, 8'h00, q);
    chk(32'(q), 32'h42);
    // float command, then a reset part way through it
    i_ahs_host.acc(1'b1, 1'b0, 8'h80, q);
    chk(top, 32'hFF123456);
    chk(sec, 32'h781F1E1D);
    tk;
    rst = 1'b1;
    repeat (5) tk;
    rst = 1'b0;
    chk({busy, done_n, svc, pause_n, oe}, 5'b01010);
    i_ahs_host.acc(1'b1, 1'b1, 8'h00, q);
    chk(32'(q), 32'h00);
    // stack bytes survive reset, top pointer restarts at zero
    for (i = 0; i < 2; i = i + 1)
    begin
      i_ahs_host.acc(1'b0, 1'b1, 8'h00, q);
      chk(32'(q), 32'(8'h1F - i[7:0]));
    end
    end_sim;
  end
endmodule

`default_nettype wire
